// ==== verilog/aop_pkg.sv ====
// How it works
// - Speaker mixer sources: aux bit 5, bypass 1, converter 0; reset off.
// - Speaker volume bit 8 attenuates bypass into speaker mixer by 10 dB.
// - Six-bit speaker gain, 1 dB steps, -57 to +6 dB, reset code 0 dB.
// - Speaker zero-cross bit 7 defers new gain to a zero crossing.
// - Speaker silence bit 6 resets set; outputs hold DC reference while set.
// - With slow clock on, pending gain applies on timeout without crossing.
// - Timeout rate is set by the slow clock divider alone; there is no rate select.
// - Additional control bit 0 enables shared slow clock; reset off.
// - Slow clock period is two to the twenty-first master clock cycles.
// - Single mixer sources: aux bit 2, bypass 1, converter 0; reset off.
// - Single mixer bit 7 attenuates bypass into single mixer by 10 dB.
// - Single mixer bit 6 silences single output onto midrail; reset clear.
// - Power three: single driver bit 7, negative 6, positive 5; reset off.
// - Power three: single mixer enable bit 3, speaker mixer bit 2.
// - Power one: amplifier bias bit 3, midrail buffer bit 2; reset off.
// - Output control bit 0 picks tie-off resistance, clear low, set high.
// - Output with enable clear ties off via chosen resistance, else drives.
package aop_pkg;

    // =========================================================
    // Register map
    localparam logic [6:0] ADDR_POWER_ONE      = 7'h01;
    localparam logic [6:0] ADDR_POWER_THREE    = 7'h03;
    localparam logic [6:0] ADDR_ADDITIONAL     = 7'h07;
    localparam logic [6:0] ADDR_OUTPUT_CTRL    = 7'h31;
    localparam logic [6:0] ADDR_SPEAKER_MIXER  = 7'h32;
    localparam logic [6:0] ADDR_SPEAKER_VOLUME = 7'h36;
    localparam logic [6:0] ADDR_SINGLE_MIXER   = 7'h38;

    localparam int REG_W  = 9;
    localparam int ADDR_W = 7;
    localparam int GAIN_W = 6;

    // =========================================================
    // Implemented bits per register, others read zero
    localparam logic [8:0] MASK_POWER_ONE      = 9'h00c;
    localparam logic [8:0] MASK_POWER_THREE    = 9'h0ec;
    localparam logic [8:0] MASK_ADDITIONAL     = 9'h001;
    localparam logic [8:0] MASK_OUTPUT_CTRL    = 9'h001;
    localparam logic [8:0] MASK_SPEAKER_MIXER  = 9'h023;
    localparam logic [8:0] MASK_SPEAKER_VOLUME = 9'h1ff;
    localparam logic [8:0] MASK_SINGLE_MIXER   = 9'h0c7;

    // =========================================================
    // Reset values
    localparam logic [8:0] RST_ZERO            = 9'h000;
    localparam logic [8:0] RST_SPEAKER_VOLUME  = 9'h079;
    localparam logic [5:0] RST_GAIN_CODE       = 6'h39;

    // =========================================================
    // Field positions
    localparam int B_BIAS_ON        = 3;
    localparam int B_MIDRAIL_ON     = 2;
    localparam int B_SINGLE_DRV     = 7;
    localparam int B_SPK_NEG_DRV    = 6;
    localparam int B_SPK_POS_DRV    = 5;
    localparam int B_SINGLE_MIXER   = 3;
    localparam int B_SPK_MIXER      = 2;
    localparam int B_SLOW_TICK_EN   = 0;
    localparam int B_TIEOFF_SEL     = 0;
    localparam int B_AUX_TO_SPK     = 5;
    localparam int B_BYP_TO_SPK     = 1;
    localparam int B_CNV_TO_SPK     = 0;
    localparam int B_SPK_ATTEN      = 8;
    localparam int B_SPK_ZC         = 7;
    localparam int B_SPK_SILENCE    = 6;
    localparam int B_SINGLE_ATTEN   = 7;
    localparam int B_SINGLE_SILENCE = 6;
    localparam int B_AUX_TO_SINGLE  = 2;
    localparam int B_BYP_TO_SINGLE  = 1;
    localparam int B_CNV_TO_SINGLE  = 0;

    // =========================================================
    // Timing
    localparam int SLOW_DIV_LOG2    = 21;

endpackage

// ==== verilog/aop_slow_tick.sv ====
`timescale 1ns/1ns
module aop_slow_tick #(
    parameter int DIV_LOG2 = aop_pkg::SLOW_DIV_LOG2
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic enable,
    output logic      tick
);

    logic [DIV_LOG2-1:0] count_r;
    logic [DIV_LOG2-1:0] count_nxt;
    logic                tick_r;
    logic                tick_nxt;

    // =========================================================
    // Divider
    // divide by power
    always_comb begin
        count_nxt = '0;
        tick_nxt  = 1'b0;
        // Held at zero while off so each start gives a full period
        if (enable) begin
            count_nxt = count_r + 1'b1;
            tick_nxt  = &count_r;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule

// ==== verilog/aop_output_ctrl.sv ====
`timescale 1ns/1ns
module aop_output_ctrl #(
    parameter int SLOW_DIV_LOG2 = aop_pkg::SLOW_DIV_LOG2
) (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [6:0] reg_addr,
    input  wire logic [8:0] reg_wdata,
    output logic      [8:0] reg_rdata,
    input  wire logic       zero_cross,
    output logic      [5:0] speaker_gain_code,
    output logic            gain_update_pending,
    output logic            speaker_silence,
    output logic            speaker_bypass_attenuate,
    output logic            aux_to_speaker_mix,
    output logic            bypass_to_speaker_mix,
    output logic            converter_to_speaker_mix,
    output logic            single_out_bypass_attenuate,
    output logic            single_out_silence,
    output logic            aux_to_single_mix,
    output logic            bypass_to_single_mix,
    output logic            converter_to_single_mix,
    output logic            amplifier_bias_on,
    output logic            midrail_buffer_on,
    output logic            single_driver_on,
    output logic            speaker_neg_driver_on,
    output logic            speaker_pos_driver_on,
    output logic            single_mixer_on,
    output logic            speaker_mixer_on,
    output logic            slow_tick_enable,
    output logic            tieoff_resistance_select,
    output logic            speaker_positive_tieoff,
    output logic            speaker_negative_tieoff,
    output logic            single_output_tieoff
);

    // =========================================================
    // Helpers
    // Address compare shared by write and read decode
    function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
        hit = (a == b);
    endfunction

    // =========================================================
    // Register file state
    logic [8:0] pwr1_r;
    logic [8:0] pwr1_nxt;
    logic [8:0] pwr3_r;
    logic [8:0] pwr3_nxt;
    logic [8:0] addl_r;
    logic [8:0] addl_nxt;
    logic [8:0] outc_r;
    logic [8:0] outc_nxt;
    logic [8:0] smix_r;
    logic [8:0] smix_nxt;
    logic [8:0] svol_r;
    logic [8:0] svol_nxt;
    logic [8:0] mmix_r;
    logic [8:0] mmix_nxt;
    logic [8:0] rdata_r;
    logic [8:0] rdata_nxt;

    always_comb begin
        pwr1_nxt  = pwr1_r;
        pwr3_nxt  = pwr3_r;
        addl_nxt  = addl_r;
        outc_nxt  = outc_r;
        smix_nxt  = smix_r;
        svol_nxt  = svol_r;
        mmix_nxt  = mmix_r;
        rdata_nxt = rdata_r;
        // Unimplemented bits are dropped and read zero
        if (reg_wr_en) begin
            if (hit(reg_addr, aop_pkg::ADDR_POWER_ONE))
                pwr1_nxt = reg_wdata & aop_pkg::MASK_POWER_ONE;

            if (hit(reg_addr, aop_pkg::ADDR_POWER_THREE))
                pwr3_nxt = reg_wdata & aop_pkg::MASK_POWER_THREE;

            if (hit(reg_addr, aop_pkg::ADDR_ADDITIONAL))
                addl_nxt = reg_wdata & aop_pkg::MASK_ADDITIONAL;

            if (hit(reg_addr, aop_pkg::ADDR_OUTPUT_CTRL))
                outc_nxt = reg_wdata & aop_pkg::MASK_OUTPUT_CTRL;

            if (hit(reg_addr, aop_pkg::ADDR_SPEAKER_MIXER))
                smix_nxt = reg_wdata & aop_pkg::MASK_SPEAKER_MIXER;

            if (hit(reg_addr, aop_pkg::ADDR_SPEAKER_VOLUME))
                svol_nxt = reg_wdata & aop_pkg::MASK_SPEAKER_VOLUME;

            if (hit(reg_addr, aop_pkg::ADDR_SINGLE_MIXER))
                mmix_nxt = reg_wdata & aop_pkg::MASK_SINGLE_MIXER;
        end

        // Read and write together return the old contents
        if (reg_rd_en) begin
            case (1'b1)
                hit(reg_addr, aop_pkg::ADDR_POWER_ONE):
                    rdata_nxt = pwr1_r;
                hit(reg_addr, aop_pkg::ADDR_POWER_THREE):
                    rdata_nxt = pwr3_r;
                hit(reg_addr, aop_pkg::ADDR_ADDITIONAL):
                    rdata_nxt = addl_r;
                hit(reg_addr, aop_pkg::ADDR_OUTPUT_CTRL):
                    rdata_nxt = outc_r;
                hit(reg_addr, aop_pkg::ADDR_SPEAKER_MIXER):
                    rdata_nxt = smix_r;
                hit(reg_addr, aop_pkg::ADDR_SPEAKER_VOLUME):
                    rdata_nxt = svol_r;
                hit(reg_addr, aop_pkg::ADDR_SINGLE_MIXER):
                    rdata_nxt = mmix_r;
                default:
                    rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr1_r  <= aop_pkg::RST_ZERO;
            pwr3_r  <= aop_pkg::RST_ZERO;
            addl_r  <= aop_pkg::RST_ZERO;
            outc_r  <= aop_pkg::RST_ZERO;
            smix_r  <= aop_pkg::RST_ZERO;
            svol_r  <= aop_pkg::RST_SPEAKER_VOLUME;
            mmix_r  <= aop_pkg::RST_ZERO;
            rdata_r <= aop_pkg::RST_ZERO;
        end else begin
            pwr1_r  <= pwr1_nxt;
            pwr3_r  <= pwr3_nxt;
            addl_r  <= addl_nxt;
            outc_r  <= outc_nxt;
            smix_r  <= smix_nxt;
            svol_r  <= svol_nxt;
            mmix_r  <= mmix_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // =========================================================
    // Zero-cross input synchroniser
    // First stage may be metastable; only the next stage reads it
    logic zc_s1_r;
    logic zc_s2_r;
    logic zc_s3_r;
    logic zc_level_r;
    logic zc_level_nxt;
    logic zc_event;

    always_comb begin
        zc_level_nxt = zc_level_r;
        // Only a level confirmed by two stages counts as a crossing
        if (zc_s2_r == zc_s3_r)
            zc_level_nxt = zc_s3_r;
    end

    // Reset low matches an idle comparator, so no false edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            zc_s1_r    <= 1'b0;
            zc_s2_r    <= 1'b0;
            zc_s3_r    <= 1'b0;
            zc_level_r <= 1'b0;
        end else begin
            zc_s1_r    <= zero_cross;
            zc_s2_r    <= zc_s1_r;
            zc_s3_r    <= zc_s2_r;
            zc_level_r <= zc_level_nxt;
        end
    end

    // Either edge of the comparator marks a crossing
    assign zc_event = zc_level_nxt != zc_level_r;

    // =========================================================
    // Slow clock
    logic slow_tick;

    // One cycle wide; with the enable off no timeout ever fires
    // shared slow clock
    aop_slow_tick #(
        .DIV_LOG2 (SLOW_DIV_LOG2)
    ) u_slow_tick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .enable  (addl_r[aop_pkg::B_SLOW_TICK_EN]),
        .tick    (slow_tick)
    );

    // =========================================================
    // Applied gain
    logic [5:0] gain_r;
    logic [5:0] gain_nxt;
    logic       pend_r;
    logic       pend_nxt;
    logic       vol_wr;

    // Only the volume register carries a deferred code
    assign vol_wr = reg_wr_en
                  && hit(reg_addr, aop_pkg::ADDR_SPEAKER_VOLUME);

    always_comb begin
        gain_nxt = gain_r;
        pend_nxt = pend_r;

        // Target is the stored code, so a rewrite replaces it
        // Timeout rate is set by the divider alone, no rate select
        // crossing or timeout
        if (pend_r && (zc_event || slow_tick)) begin
            gain_nxt = svol_r[aop_pkg::GAIN_W-1:0];
            pend_nxt = 1'b0;
        end

        // A write in the same cycle wins and replaces the pending code
        if (vol_wr) begin
            if (reg_wdata[aop_pkg::B_SPK_ZC]) begin
                pend_nxt = 1'b1;
            end else begin
                gain_nxt = reg_wdata[aop_pkg::GAIN_W-1:0];
                pend_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_r <= aop_pkg::RST_GAIN_CODE;
            pend_r <= 1'b0;
        end else begin
            gain_r <= gain_nxt;
            pend_r <= pend_nxt;
        end
    end

    // =========================================================
    // Tie-off state
    logic sp_tie_r;
    logic sp_tie_nxt;
    logic sn_tie_r;
    logic sn_tie_nxt;
    logic so_tie_r;
    logic so_tie_nxt;

    // Taken from the next enable so both switch on one edge
    // disabled output ties off
    always_comb begin
        sp_tie_nxt = !pwr3_nxt[aop_pkg::B_SPK_POS_DRV];
        sn_tie_nxt = !pwr3_nxt[aop_pkg::B_SPK_NEG_DRV];
        so_tie_nxt = !pwr3_nxt[aop_pkg::B_SINGLE_DRV];
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_tie_r <= 1'b1;
            sn_tie_r <= 1'b1;
            so_tie_r <= 1'b1;
        end else begin
            sp_tie_r <= sp_tie_nxt;
            sn_tie_r <= sn_tie_nxt;
            so_tie_r <= so_tie_nxt;
        end
    end

    // =========================================================
    // Outputs, all straight from flops
    assign reg_rdata                   = rdata_r;
    assign speaker_gain_code           = gain_r;
    assign gain_update_pending         = pend_r;

    assign speaker_silence             = svol_r[aop_pkg::B_SPK_SILENCE];
    assign speaker_bypass_attenuate    = svol_r[aop_pkg::B_SPK_ATTEN];
    assign aux_to_speaker_mix          = smix_r[aop_pkg::B_AUX_TO_SPK];
    assign bypass_to_speaker_mix       = smix_r[aop_pkg::B_BYP_TO_SPK];
    assign converter_to_speaker_mix    = smix_r[aop_pkg::B_CNV_TO_SPK];

    assign single_out_bypass_attenuate = mmix_r[aop_pkg::B_SINGLE_ATTEN];
    assign single_out_silence          = mmix_r[aop_pkg::B_SINGLE_SILENCE];
    assign aux_to_single_mix           = mmix_r[aop_pkg::B_AUX_TO_SINGLE];
    assign bypass_to_single_mix        = mmix_r[aop_pkg::B_BYP_TO_SINGLE];
    assign converter_to_single_mix     = mmix_r[aop_pkg::B_CNV_TO_SINGLE];

    assign amplifier_bias_on           = pwr1_r[aop_pkg::B_BIAS_ON];
    assign midrail_buffer_on           = pwr1_r[aop_pkg::B_MIDRAIL_ON];
    assign single_driver_on            = pwr3_r[aop_pkg::B_SINGLE_DRV];
    assign speaker_neg_driver_on       = pwr3_r[aop_pkg::B_SPK_NEG_DRV];
    assign speaker_pos_driver_on       = pwr3_r[aop_pkg::B_SPK_POS_DRV];
    assign single_mixer_on             = pwr3_r[aop_pkg::B_SINGLE_MIXER];
    assign speaker_mixer_on            = pwr3_r[aop_pkg::B_SPK_MIXER];

    assign slow_tick_enable            = addl_r[aop_pkg::B_SLOW_TICK_EN];
    assign tieoff_resistance_select    = outc_r[aop_pkg::B_TIEOFF_SEL];
    // High means the pin rests on its tie-off resistor
    assign speaker_positive_tieoff     = sp_tie_r;
    assign speaker_negative_tieoff     = sn_tie_r;
    assign single_output_tieoff        = so_tie_r;

endmodule

// ==== testbench/aop_output_ctrl_assertions.sv ====
`timescale 1ns/1ns
module aop_output_ctrl_assertions #(
    parameter int SLOW_DIV_LOG2 = 21
) (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic       reg_wr_en,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    input wire logic [5:0] speaker_gain_code,
    input wire logic       gain_update_pending,
    input wire logic       speaker_silence,
    input wire logic       speaker_bypass_attenuate,
    input wire logic       aux_to_speaker_mix,
    input wire logic       bypass_to_speaker_mix,
    input wire logic       converter_to_speaker_mix,
    input wire logic       single_out_bypass_attenuate,
    input wire logic       single_out_silence,
    input wire logic       aux_to_single_mix,
    input wire logic       bypass_to_single_mix,
    input wire logic       converter_to_single_mix,
    input wire logic       amplifier_bias_on,
    input wire logic       midrail_buffer_on,
    input wire logic       single_driver_on,
    input wire logic       speaker_neg_driver_on,
    input wire logic       speaker_pos_driver_on,
    input wire logic       single_mixer_on,
    input wire logic       speaker_mixer_on,
    input wire logic       slow_tick_enable,
    input wire logic       tieoff_resistance_select,
    input wire logic       speaker_positive_tieoff,
    input wire logic       speaker_negative_tieoff,
    input wire logic       single_output_tieoff
);
    logic [31:0] wait_r;
    logic [31:0] wait_nxt;
    logic        w36;

    assign w36 = reg_wr_en && reg_addr == 7'h36;

    // ==========
    // Pending age, only while the timeout source runs
    always_comb begin
        wait_nxt = (gain_update_pending && slow_tick_enable) ? wait_r + 1 : 0;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_r <= 32'h0;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ==========
    // Properties
    immediate_gain_a: assert property (
        w36 && !reg_wdata[7] |=> !gain_update_pending &&
        speaker_gain_code == $past(reg_wdata[5:0]))
        else $error("immediate gain not applied");
    deferred_gain_a: assert property (
        w36 && reg_wdata[7] |=> gain_update_pending
        && $stable(speaker_gain_code))
        else $error("deferred gain not held");
    speaker_bits_a: assert property (
        w36 |=> {speaker_bypass_attenuate, speaker_silence}
        == $past({reg_wdata[8], reg_wdata[6]}))
        else $error("speaker volume bits wrong");
    speaker_mix_a: assert property (
        reg_wr_en && reg_addr == 7'h32 |=> {aux_to_speaker_mix,
        bypass_to_speaker_mix, converter_to_speaker_mix}
        == $past({reg_wdata[5], reg_wdata[1:0]}))
        else $error("speaker mix select wrong");
    single_mix_a: assert property (
        reg_wr_en && reg_addr == 7'h38 |=> {single_out_bypass_attenuate,
        single_out_silence, aux_to_single_mix, bypass_to_single_mix,
        converter_to_single_mix} == $past({reg_wdata[7:6], reg_wdata[2:0]}))
        else $error("single mixer bits wrong");
    power_three_a: assert property (
        reg_wr_en && reg_addr == 7'h03 |=> {single_driver_on,
        speaker_neg_driver_on, speaker_pos_driver_on, single_mixer_on,
        speaker_mixer_on} == $past({reg_wdata[7:5], reg_wdata[3:2]}))
        else $error("power three enables wrong");
    power_one_a: assert property (
        reg_wr_en && reg_addr == 7'h01 |=> {amplifier_bias_on,
        midrail_buffer_on} == $past(reg_wdata[3:2]))
        else $error("power one enables wrong");
    slow_enable_a: assert property (
        reg_wr_en && reg_addr == 7'h07 |=>
        slow_tick_enable == $past(reg_wdata[0]))
        else $error("slow tick enable wrong");
    tieoff_select_a: assert property (
        reg_wr_en && reg_addr == 7'h31 |=>
        tieoff_resistance_select == $past(reg_wdata[0]))
        else $error("tie-off select wrong");
    tieoff_follow_a: assert property (
        {speaker_positive_tieoff, speaker_negative_tieoff,
        single_output_tieoff} == ~{speaker_pos_driver_on,
        speaker_neg_driver_on, single_driver_on})
        else $error("tie-off not inverse of enable");
    timeout_bound_a: assert property (
        wait_r <= (32'd1 << SLOW_DIV_LOG2) + 32'd4)
        else $error("pending gain outlived timeout");

    cover property (w36 && reg_wdata[7]);
    cover property ($fell(gain_update_pending) && slow_tick_enable);
    cover property ($fell(single_output_tieoff));
endmodule

bind aop_output_ctrl aop_output_ctrl_assertions #(
    .SLOW_DIV_LOG2(SLOW_DIV_LOG2)
) aop_output_ctrl_assertions_i (
    .ref_clk, .arst_n, .reg_wr_en, .reg_addr, .reg_wdata,
    .speaker_gain_code, .gain_update_pending, .speaker_silence,
    .speaker_bypass_attenuate, .aux_to_speaker_mix, .bypass_to_speaker_mix,
    .converter_to_speaker_mix, .single_out_bypass_attenuate,
    .single_out_silence, .aux_to_single_mix, .bypass_to_single_mix,
    .converter_to_single_mix, .amplifier_bias_on, .midrail_buffer_on,
    .single_driver_on, .speaker_neg_driver_on, .speaker_pos_driver_on,
    .single_mixer_on, .speaker_mixer_on, .slow_tick_enable,
    .tieoff_resistance_select, .speaker_positive_tieoff,
    .speaker_negative_tieoff, .single_output_tieoff
);

// ==== testbench/aop_output_ctrl_tb.sv ====
`timescale 1ns/1ns
module aop_output_ctrl_tb;
    logic       ref_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       reg_wr_en = 1'b0;
    logic       reg_rd_en = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wdata = 9'h000;
    logic       zero_cross = 1'b0;
    logic [8:0] reg_rdata;
    logic [5:0] speaker_gain_code;
    logic gain_update_pending, speaker_silence, speaker_bypass_attenuate,
        aux_to_speaker_mix, bypass_to_speaker_mix, converter_to_speaker_mix,
        single_out_bypass_attenuate, single_out_silence, aux_to_single_mix,
        bypass_to_single_mix, converter_to_single_mix, amplifier_bias_on,
        midrail_buffer_on, single_driver_on, speaker_neg_driver_on,
        speaker_pos_driver_on, single_mixer_on, speaker_mixer_on,
        slow_tick_enable, tieoff_resistance_select, speaker_positive_tieoff,
        speaker_negative_tieoff, single_output_tieoff;
    int         failures = 0;
    int         comparisons = 0;
    // ==========
    // Model of register contents and applied gain
    logic [8:0] m [0:127];
    logic [5:0] g;
    logic [5:0] pc;
    logic       p;
    logic [6:0] a;
    logic [8:0] d;
    logic [6:0] amap [8] = '{7'h01, 7'h03, 7'h07, 7'h31, 7'h32, 7'h36,
        7'h38, 7'h05};

    always #25 ref_clk = ~ref_clk;

    aop_output_ctrl #(.SLOW_DIV_LOG2(4)) aop_output_ctrl_i (
        .ref_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .zero_cross, .speaker_gain_code, .gain_update_pending,
        .speaker_silence, .speaker_bypass_attenuate, .aux_to_speaker_mix,
        .bypass_to_speaker_mix, .converter_to_speaker_mix,
        .single_out_bypass_attenuate, .single_out_silence, .aux_to_single_mix,
        .bypass_to_single_mix, .converter_to_single_mix, .amplifier_bias_on,
        .midrail_buffer_on, .single_driver_on, .speaker_neg_driver_on,
        .speaker_pos_driver_on, .single_mixer_on, .speaker_mixer_on,
        .slow_tick_enable, .tieoff_resistance_select, .speaker_positive_tieoff,
        .speaker_negative_tieoff, .single_output_tieoff);

    function automatic logic [8:0] msk(input logic [6:0] ad);
        case (ad)
            7'h01: msk = 9'h00c;
            7'h03: msk = 9'h0ec;
            7'h07, 7'h31: msk = 9'h001;
            7'h32: msk = 9'h023;
            7'h36: msk = 9'h1ff;
            7'h38: msk = 9'h0c7;
            default: msk = 9'h000;
        endcase
    endfunction

    task automatic init_model;
        foreach (m[i]) m[i] = 9'h000;
        m[7'h36] = 9'h079;
        g = 6'h39;
        p = 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [6:0] ad, input logic [8:0] dt);
        // One edge between requests so a strobe never drops and rises at once
        @(posedge ref_clk);
        #2 reg_addr = ad;
        reg_wdata = dt;
        reg_wr_en = 1'b1;
        @(posedge ref_clk);
        #2 reg_wr_en = 1'b0;
        m[ad] = dt & msk(ad);
        if (ad == 7'h36) begin
            p = dt[7];
            pc = dt[5:0];
            if (!dt[7]) g = dt[5:0];
        end
    endtask

    task automatic rd(input logic [6:0] ad);
        @(posedge ref_clk);
        #2 reg_addr = ad;
        reg_rd_en = 1'b1;
        @(posedge ref_clk);
        #2 reg_rd_en = 1'b0;
        chk("rdata", reg_rdata, m[ad]);
    endtask

    task automatic outs;
        chk("gain", speaker_gain_code, g);
        chk("pending", gain_update_pending, p);
        chk("controls", {speaker_bypass_attenuate, speaker_silence,
            aux_to_speaker_mix, bypass_to_speaker_mix,
            converter_to_speaker_mix, single_out_bypass_attenuate,
            single_out_silence, aux_to_single_mix, bypass_to_single_mix,
            converter_to_single_mix, amplifier_bias_on, midrail_buffer_on,
            single_driver_on, speaker_neg_driver_on, speaker_pos_driver_on,
            single_mixer_on, speaker_mixer_on, slow_tick_enable,
            tieoff_resistance_select, speaker_positive_tieoff,
            speaker_negative_tieoff, single_output_tieoff},
            {m[7'h36][8], m[7'h36][6], m[7'h32][5], m[7'h32][1:0],
            m[7'h38][7:6], m[7'h38][2:0], m[7'h01][3:2], m[7'h03][7:5],
            m[7'h03][3:2], m[7'h07][0], m[7'h31][0], ~m[7'h03][5],
            ~m[7'h03][6], ~m[7'h03][7]});
    endtask

    // Bounded wait for a deferred gain to land
    task automatic wait_apply(input int lim);
        int i;
        for (i = 0; i < lim && gain_update_pending !== 1'b0; i++) begin
            @(posedge ref_clk);
            #2;
        end
        chk("apply wait", gain_update_pending, 1'b0);
        // A used-up bound ends the run
        if (gain_update_pending !== 1'b0) begin
            print_verdict;
        end else begin
            p = 1'b0;
            g = pc;
        end
    endtask

    initial begin
        void'($urandom(32'h42719cd6));
        init_model;
        repeat (5) @(posedge ref_clk);
        #2 arst_n = 1'b1;
        outs;
        foreach (amap[i]) rd(amap[i]);
        // Random traffic, unmapped address included; slow tick kept off
        // so that only writes move the gain. Enables with the midrail
        // buffer off are accepted, no interlock.
        repeat (60) begin
            a = amap[$urandom_range(7, 0)];
            d = 9'($urandom);
            if (a == 7'h07) d[0] = 1'b0;
            wr(a, d);
            outs;
            rd(a);
        end
        wr(7'h36, 9'h000);
        outs;
        // Deferred code replaced by a rewrite, then a crossing
        wr(7'h36, 9'h0bf);
        wr(7'h36, 9'h0b0);
        repeat (3) @(posedge ref_clk);
        #2 outs;
        zero_cross = ~zero_cross;
        wait_apply(10);
        outs;
        // No timeout while the slow tick is off
        wr(7'h36, 9'h0a5);
        repeat (40) @(posedge ref_clk);
        #2 outs;
        wr(7'h07, 9'h001);
        wait_apply(40);
        outs;
        wr(7'h36, 9'h0bf);
        wait_apply(40);
        outs;
        wr(7'h36, 9'h03f);
        outs;
        // Second reset mid run
        arst_n = 1'b0;
        @(posedge ref_clk);
        #2 arst_n = 1'b1;
        init_model;
        outs;
        rd(7'h36);
        print_verdict;
    end
endmodule
